// *** logic/ledks_pkg.sv ***
// Shared constants, types and helpers for the LED keyscan serial link
package ledks_pkg;
   localparam int BYTE_W = 8;
   localparam int SEG_N = 8;
   localparam int DIG_N = 7;
   localparam int RET_N = 2;
   localparam int KEY_W = SEG_N * RET_N;
   localparam int SLOT_W = 4;
   localparam int BITS_W = 6;
   // Opcode field of a command byte
   localparam int OP_LSB = 5;
   localparam int IDX_W = 3;
   localparam logic [2:0] OP_WRITE_DIGIT = 3'h1;
   localparam logic [2:0] OP_DISPLAY_ON = 3'h2;
   localparam logic [2:0] OP_DISPLAY_OFF = 3'h3;
   localparam logic [2:0] OP_READ_KEYS = 3'h4;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // Scan timing and host divider defaults, in mclk cycles
   localparam int SCAN_SLOT_CYCLES = 256;
   localparam int HOST_HALF_DIV = 4;
   localparam logic [BITS_W-1:0] BYTE_BITS = 6'h08;
   localparam logic [BITS_W-1:0] WORD_BITS = 6'h10;

   typedef enum logic [1:0] {
      LEDKS_RX_CMD, LEDKS_RX_DATA, LEDKS_RX_READ, LEDKS_RX_DONE
   } ledks_rx_t;

   typedef enum logic [2:0] {
      LEDKS_H_IDLE, LEDKS_H_LEAD, LEDKS_H_LOW, LEDKS_H_HIGH, LEDKS_H_TAIL,
      LEDKS_H_GAP
   } ledks_host_t;

   // Opcode of a command byte
   function automatic logic [2:0] ledks_op(input logic [BYTE_W-1:0] b);
      return b[BYTE_W-1:OP_LSB];
   endfunction : ledks_op

   // One-hot select of one line out of eight
   function automatic logic [SEG_N-1:0] ledks_onehot(input logic [3:0] i);
      logic [SEG_N-1:0] v;
      v = '0;
      if (i < 4'(SEG_N)) begin
         v[i[2:0]] = 1'b1;
      end
      return v;
   endfunction : ledks_onehot
endpackage : ledks_pkg

// *** logic/ledks_link_if.sv ***
// Three-wire link between host and display controller, with pulled-up data
`timescale 1ns/100ps
interface ledks_link_if;
   logic sclk;
   logic frame_select_n;
   logic host_dout;
   logic host_oe;
   logic dev_dout;
   logic dev_oe;
   wire logic dio;

   // External pull-up holds the line high when nobody drives
   assign dio = host_oe ? host_dout : (dev_oe ? dev_dout : 1'b1);

   modport dev (
      input sclk,
      input frame_select_n,
      input dio,
      output dev_dout,
      output dev_oe
   );
   modport host (
      output sclk,
      output frame_select_n,
      output host_dout,
      output host_oe,
      input dio
   );
endinterface : ledks_link_if

// *** logic/ledks_host.sv ***
// Host end: makes the link clock and frames commands and key reads
`timescale 1ns/100ps
module ledks_host #(
   parameter int HALF_DIV = ledks_pkg::HOST_HALF_DIV
) (
   input wire logic mclk,
   input wire logic reset_n,
   ledks_link_if.host link,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [ledks_pkg::BYTE_W-1:0] req_cmd,
   input wire logic [ledks_pkg::BYTE_W-1:0] req_data,
   input wire logic req_has_data,
   input wire logic req_read,
   output logic rsp_valid,
   output logic [ledks_pkg::KEY_W-1:0] rsp_keys
);
   import ledks_pkg::*;

   ledks_host_t st_q;
   logic [7:0] div_q;
   logic half_end;
   logic [BITS_W-1:0] bits_q;
   logic [BITS_W-1:0] tx_bits_q;
   logic [BITS_W-1:0] total_q;
   logic [KEY_W-1:0] sh_q;
   logic [KEY_W-1:0] rx_q;
   logic sclk_q, fs_q, dout_q, oe_q;
   logic dio_meta_q, dio_sync_q;
   logic [BITS_W-1:0] nb;
   logic [KEY_W-1:0] sh_next;

   assign half_end = (div_q == 8'(HALF_DIV - 1));
   assign nb = bits_q + 6'h01;
   assign sh_next = {1'b0, sh_q[KEY_W-1:1]};

   // Returned data comes from the far clock domain
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         dio_meta_q <= 1'b1;
         dio_sync_q <= 1'b1;
      end else begin
         dio_meta_q <= link.dio;
         dio_sync_q <= dio_meta_q;
      end
   end

   // Half-period divider for the link clock
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         div_q <= 8'h00;
      end else if (st_q == LEDKS_H_IDLE || half_end) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   // Frame sequencer; data changes on falling clock, device samples rising
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= LEDKS_H_IDLE;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_keys <= '0;
         bits_q <= '0;
         tx_bits_q <= '0;
         total_q <= '0;
         sh_q <= '0;
         rx_q <= '0;
         sclk_q <= 1'b1;
         fs_q <= 1'b1;
         dout_q <= 1'b1;
         oe_q <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         unique case (st_q)
            LEDKS_H_IDLE: begin
               req_ready <= 1'b1;
               if (req_valid && req_ready) begin
                  req_ready <= 1'b0;
                  sh_q <= {req_data, req_cmd};
                  tx_bits_q <= req_has_data ? WORD_BITS : BYTE_BITS;
                  total_q <= (req_has_data ? WORD_BITS : BYTE_BITS) +
                     (req_read ? WORD_BITS : 6'h00);
                  bits_q <= '0;
                  fs_q <= 1'b0; // R4
                  st_q <= LEDKS_H_LEAD;
               end
            end
            LEDKS_H_LEAD: begin
               if (half_end) begin
                  sclk_q <= 1'b0;
                  dout_q <= sh_q[0]; // R1
                  oe_q <= 1'b1;
                  st_q <= LEDKS_H_LOW;
               end
            end
            LEDKS_H_LOW: begin
               if (half_end) begin
                  sclk_q <= 1'b1;
                  st_q <= LEDKS_H_HIGH;
               end
            end
            LEDKS_H_HIGH: begin
               if (half_end) begin
                  // Sample at end of high phase, data valid all through it
                  if (bits_q >= tx_bits_q) begin
                     rx_q <= {dio_sync_q, rx_q[KEY_W-1:1]}; // R9
                  end
                  sh_q <= sh_next;
                  bits_q <= nb;
                  if (nb == total_q) begin
                     st_q <= LEDKS_H_TAIL;
                  end else begin
                     sclk_q <= 1'b0;
                     dout_q <= sh_next[0];
                     oe_q <= (nb < tx_bits_q);
                     st_q <= LEDKS_H_LOW;
                  end
               end
            end
            LEDKS_H_TAIL: begin
               if (half_end) begin
                  fs_q <= 1'b1;
                  oe_q <= 1'b0;
                  dout_q <= 1'b1;
                  rsp_valid <= (total_q > tx_bits_q);
                  rsp_keys <= rx_q;
                  st_q <= LEDKS_H_GAP;
               end
            end
            LEDKS_H_GAP: begin
               if (half_end) begin
                  st_q <= LEDKS_H_IDLE;
               end
            end
            default: st_q <= LEDKS_H_IDLE;
         endcase
      end
   end

   assign link.sclk = sclk_q;
   assign link.frame_select_n = fs_q;
   assign link.host_dout = dout_q;
   assign link.host_oe = oe_q;
endmodule : ledks_host

// *** logic/ledks_dev.sv ***
// Display controller end: serial front end, display scan and key scan
// Function
// R1: Sample data on rising clock, LSB first
// R2: Drive read data on falling clock, LSB first
// R3: Strobe edges reset the serial receiver
// R4: Data after strobe falls starts a command
// R5: New command aborts and restarts serial interface
// R6: Ignore clock and data while strobe high
// R7: Eight-bit shift register, decode complete bytes
// R8: Partial byte discarded, configuration kept
// R9: Data valid during high clock phase
// R10: Interrupt output low on key press
// R11: Latch both key returns each cycle end
// R12: Segment lines double as key sources
// R13: Power-up resets, blanks, low power, outputs off
// R14: Low power keeps configuration, restores outputs
// R15: Host configures device before display works
// R16: Any key combination reported correctly
// R17: Discrete LED common scanned like a digit
// R18: Digits source anodes, segments sink cathodes
// R19: Data line released unless returning read data
`timescale 1ns/100ps
module ledks_dev #(
   parameter int SLOT_CYCLES = ledks_pkg::SCAN_SLOT_CYCLES
) (
   input wire logic mclk,
   input wire logic reset_n,
   ledks_link_if.dev link,
   output logic [ledks_pkg::DIG_N-1:0] digit_src_en,
   output logic [ledks_pkg::SEG_N-1:0] seg_sink_en,
   output logic [ledks_pkg::SEG_N-1:0] key_src_en,
   input wire logic scan_return_1,
   input wire logic scan_return_2,
   output logic key_irq_n,
   output logic display_on
);
   import ledks_pkg::*;

   localparam int SLOTS = DIG_N + SEG_N;
   localparam logic [SLOT_W-1:0] SLOT_FIRST_KEY = SLOT_W'(DIG_N);
   localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(SLOTS - 1);
   localparam logic [15:0] SLOT_CNT_LAST = 16'(SLOT_CYCLES - 1);

   // ---- link clock domain ----
   logic rx_rst_n;
   logic [BYTE_W-1:0] shift_q;
   logic [2:0] bitcnt_q;
   ledks_rx_t rx_q;
   logic [BYTE_W-1:0] cmd_q;
   logic [BYTE_W-1:0] rx_byte;
   logic byte_done;
   logic [2*BYTE_W-1:0] mail_q;
   logic mail_tgl_q;
   logic [4:0] obit_q;
   logic dout_q, oe_q;

   // ---- mclk domain ----
   logic fs_meta_q, fs_sync_q;
   logic tg_meta_q, tg_sync_q, tg_seen_q;
   logic [RET_N-1:0] ret_meta_q, ret_sync_q;
   logic [BYTE_W-1:0] seg_mem_q [DIG_N];
   logic [15:0] slot_cnt_q;
   logic [SLOT_W-1:0] slot_q;
   logic slot_end;
   logic [SLOT_W-1:0] key_idx;
   logic [KEY_W-1:0] key_acc_q;
   logic [KEY_W-1:0] key_new;
   logic [KEY_W-1:0] key_q;
   logic [KEY_W-1:0] key_snap_q;
   logic [2:0] mail_op;
   logic [BYTE_W-1:0] sel_onehot;

   // Strobe high holds the receiver in reset; both edges restart it
   assign rx_rst_n = reset_n & ~link.frame_select_n; // R3 R6 R5
   assign rx_byte = {link.dio, shift_q[BYTE_W-1:1]}; // R1
   assign byte_done = (bitcnt_q == BIT_LAST);

   // Receiver shift register and bit count
   always_ff @(posedge link.sclk or negedge rx_rst_n) begin
      if (!rx_rst_n) begin
         shift_q <= '0;
         bitcnt_q <= 3'h0;
      end else begin
         shift_q <= rx_byte; // R7 R9
         bitcnt_q <= bitcnt_q + 3'h1;
      end
   end

   // Command framing: first byte after strobe falls is the command
   always_ff @(posedge link.sclk or negedge rx_rst_n) begin
      if (!rx_rst_n) begin
         rx_q <= LEDKS_RX_CMD; // R4
         cmd_q <= '0;
      end else if (byte_done) begin
         unique case (rx_q)
            LEDKS_RX_CMD: begin
               cmd_q <= rx_byte; // R7
               if (ledks_op(rx_byte) == OP_WRITE_DIGIT) begin
                  rx_q <= LEDKS_RX_DATA;
               end else if (ledks_op(rx_byte) == OP_READ_KEYS) begin
                  rx_q <= LEDKS_RX_READ;
               end else begin
                  rx_q <= LEDKS_RX_DONE;
               end
            end
            LEDKS_RX_DATA: rx_q <= LEDKS_RX_DONE;
            LEDKS_RX_READ: rx_q <= LEDKS_RX_READ;
            LEDKS_RX_DONE: rx_q <= LEDKS_RX_DONE;
         endcase
      end
   end

   // Mailbox to mclk; survives strobe so only whole bytes ever post
   always_ff @(posedge link.sclk or negedge reset_n) begin
      if (!reset_n) begin
         mail_q <= '0;
         mail_tgl_q <= 1'b0;
      end else if (byte_done && !link.frame_select_n) begin
         if (rx_q == LEDKS_RX_CMD &&
             (ledks_op(rx_byte) == OP_DISPLAY_ON ||
              ledks_op(rx_byte) == OP_DISPLAY_OFF)) begin
            mail_q <= {rx_byte, 8'h00}; // R8
            mail_tgl_q <= ~mail_tgl_q;
         end else if (rx_q == LEDKS_RX_DATA) begin
            mail_q <= {cmd_q, rx_byte}; // R8
            mail_tgl_q <= ~mail_tgl_q;
         end
      end
   end

   // Read data leaves on the falling edge, LSB first, then line released
   always_ff @(negedge link.sclk or negedge rx_rst_n) begin
      if (!rx_rst_n) begin
         obit_q <= 5'h00;
         dout_q <= 1'b1;
         oe_q <= 1'b0; // R19
      end else if (rx_q == LEDKS_RX_READ && obit_q < 5'(KEY_W)) begin
         dout_q <= key_snap_q[obit_q[3:0]]; // R2
         oe_q <= 1'b1;
         obit_q <= obit_q + 5'h01;
      end else begin
         oe_q <= 1'b0; // R19
      end
   end

   assign link.dev_dout = dout_q;
   assign link.dev_oe = oe_q;

   // Synchronisers for strobe, mailbox toggle and key returns
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         fs_meta_q <= 1'b1;
         fs_sync_q <= 1'b1;
         tg_meta_q <= 1'b0;
         tg_sync_q <= 1'b0;
         tg_seen_q <= 1'b0;
         ret_meta_q <= '0;
         ret_sync_q <= '0;
      end else begin
         fs_meta_q <= link.frame_select_n;
         fs_sync_q <= fs_meta_q;
         tg_meta_q <= mail_tgl_q;
         tg_sync_q <= tg_meta_q;
         tg_seen_q <= tg_sync_q;
         ret_meta_q <= {scan_return_2, scan_return_1};
         ret_sync_q <= ret_meta_q;
      end
   end

   assign mail_op = ledks_op(mail_q[2*BYTE_W-1:BYTE_W]);

   // Apply posted commands; mailbox word is stable once toggle is seen
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         display_on <= 1'b0; // R13
         for (int i = 0; i < DIG_N; i++) begin
            seg_mem_q[i] <= '0; // R13
         end
      end else if (tg_sync_q != tg_seen_q) begin
         unique case (mail_op)
            OP_WRITE_DIGIT: begin
               if (mail_q[BYTE_W+IDX_W-1:BYTE_W] < 3'(DIG_N)) begin
                  seg_mem_q[mail_q[BYTE_W+IDX_W-1:BYTE_W]] <=
                     mail_q[BYTE_W-1:0];
               end
            end
            OP_DISPLAY_ON: display_on <= 1'b1; // R14
            OP_DISPLAY_OFF: display_on <= 1'b0; // R14
            default: display_on <= display_on;
         endcase
      end
   end

   // Slot timer: digit slots then one key slot per segment line
   assign slot_end = (slot_cnt_q == SLOT_CNT_LAST);
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         slot_cnt_q <= 16'h0000;
         slot_q <= '0;
      end else if (!display_on) begin
         slot_cnt_q <= 16'h0000;
         slot_q <= '0;
      end else if (slot_end) begin
         slot_cnt_q <= 16'h0000;
         slot_q <= (slot_q == SLOT_LAST) ? '0 : slot_q + 4'h1;
      end else begin
         slot_cnt_q <= slot_cnt_q + 16'h0001;
      end
   end

   assign key_idx = slot_q - SLOT_FIRST_KEY;
   assign sel_onehot =
      ledks_onehot(slot_q < SLOT_FIRST_KEY ? slot_q : key_idx);

   // Drive enables; everything released in low power
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         digit_src_en <= '0; // R13
         seg_sink_en <= '0;
         key_src_en <= '0;
      end else if (!display_on) begin
         digit_src_en <= '0; // R13
         seg_sink_en <= '0;
         key_src_en <= '0;
      end else if (slot_q < SLOT_FIRST_KEY) begin
         // Bit 0 is the discrete LED common, treated as any digit
         digit_src_en <= sel_onehot[DIG_N-1:0]; // R17 R18
         seg_sink_en <= seg_mem_q[slot_q[2:0]]; // R18 R14
         key_src_en <= '0;
      end else begin
         digit_src_en <= '0;
         seg_sink_en <= '0;
         key_src_en <= sel_onehot; // R12
      end
   end

   // Every key has its own bit, so any combination is kept
   always_comb begin
      key_new = key_acc_q;
      if (slot_q >= SLOT_FIRST_KEY) begin
         key_new[key_idx[2:0]] = ret_sync_q[0]; // R16
         key_new[SEG_N + 32'(key_idx[2:0])] = ret_sync_q[1];
      end
   end

   // Latch key map at end of each full cycle and raise interrupt
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         key_acc_q <= '0;
         key_q <= '0;
         key_irq_n <= 1'b1;
      end else if (display_on && slot_end) begin
         key_acc_q <= key_new;
         if (slot_q == SLOT_LAST) begin
            key_q <= key_new; // R11
            key_irq_n <= ~|key_new; // R10
         end
      end
   end

   // Read snapshot frozen while a frame is open, so the word cannot tear
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         key_snap_q <= '0;
      end else if (fs_sync_q) begin
         key_snap_q <= key_q;
      end
   end
endmodule : ledks_dev

// *** tb/ledks_link_sva.sv ***
// Checker for the three-wire link between host and display controller
`timescale 1ns/100ps
module ledks_link_sva (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic sclk,
   input wire logic frame_select_n,
   input wire logic host_dout,
   input wire logic host_oe,
   input wire logic dev_dout,
   input wire logic dev_oe,
   input wire logic dio
);
   logic [5:0] rise_cnt_q;

   // Link clock rises seen in this frame; cleared while the strobe is high
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rise_cnt_q <= 6'h00;
      end else if (frame_select_n) begin
         rise_cnt_q <= 6'h00;
      end else if ($rose(sclk)) begin
         rise_cnt_q <= rise_cnt_q + 6'h01;
      end
   end

   // Device lets go of the line outside frames
   property p_dev_release;
      @(posedge mclk) disable iff (!reset_n) frame_select_n |-> !dev_oe;
   endproperty
   a_dev_release: assert property (p_dev_release)
      else $error("device drives data with strobe high");

   // Never two drivers on the shared line
   property p_one_driver;
      @(posedge mclk) disable iff (!reset_n) !(host_oe && dev_oe);
   endproperty
   a_one_driver: assert property (p_one_driver)
      else $error("host and device drive the line together");

   // Pull-up shows between frames
   property p_idle_high;
      @(posedge mclk) disable iff (!reset_n) frame_select_n |-> dio;
   endproperty
   a_idle_high: assert property (p_idle_high)
      else $error("data line not high between frames");

   // Device starts driving only in the low clock phase
   property p_oe_on_fall;
      @(posedge mclk) disable iff (!reset_n) $rose(dev_oe) |-> !sclk;
   endproperty
   a_oe_on_fall: assert property (p_oe_on_fall)
      else $error("device started driving outside low clock phase");

   // Read data begins right after the eight command bits
   property p_oe_start;
      @(posedge mclk) disable iff (!reset_n)
         $rose(dev_oe) |-> rise_cnt_q == 6'h08;
   endproperty
   a_oe_start: assert property (p_oe_start)
      else $error("device drove data at wrong bit count");

   // Strobe only rises on whole bytes from the host end
   property p_whole_bytes;
      @(posedge mclk) disable iff (!reset_n) $rose(frame_select_n) |->
         (rise_cnt_q == 6'h08 || rise_cnt_q == 6'h10 || rise_cnt_q == 6'h18);
   endproperty
   a_whole_bytes: assert property (p_whole_bytes)
      else $error("frame closed on a partial byte");

   // Read bits hold through the high clock phase
   property p_dev_stable;
      @(posedge mclk) disable iff (!reset_n)
         dev_oe && $past(dev_oe) && sclk && $past(sclk) |-> $stable(dev_dout);
   endproperty
   a_dev_stable: assert property (p_dev_stable)
      else $error("read bit changed during high clock phase");

   // Write bits hold through the high clock phase
   property p_host_stable;
      @(posedge mclk) disable iff (!reset_n)
         host_oe && sclk && $past(sclk) |-> $stable(host_dout);
   endproperty
   a_host_stable: assert property (p_host_stable)
      else $error("write bit changed during high clock phase");
endmodule : ledks_link_sva

// *** tb/led_keyscan_serial_front_end_tb.sv ***
// Bench for host and display controller ends joined across the link
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
   $display("ERROR %0t: got %h want %h", $time, g, e); end end
module led_keyscan_serial_front_end_tb;
   import ledks_pkg::*;
   localparam int SLOT = 4;
   localparam logic [7:0] ON = {OP_DISPLAY_ON, 5'h00};
   localparam logic [7:0] OFF = {OP_DISPLAY_OFF, 5'h00};
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic req_valid = 1'b0;
   logic req_ready, rsp_valid, irq_n, on_a, on_b;
   logic [7:0] req_cmd = 8'h00;
   logic [7:0] req_data = 8'h00;
   logic req_has_data = 1'b0;
   logic req_read = 1'b0;
   logic ret_1 = 1'b0;
   logic ret_2 = 1'b0;
   logic [KEY_W-1:0] rsp_keys;
   logic [KEY_W-1:0] pressed = 16'h0000;
   logic [DIG_N-1:0] dig_a, dig_b;
   logic [SEG_N-1:0] seg_a, seg_b, ksrc_a;
   logic [SEG_N-1:0] mem [DIG_N];
   logic [KEY_W-1:0] pats [3] = '{16'h8101, 16'hFFFF, 16'h0000};
   int error_cnt = 0;
   int checks_done = 0;

   ledks_link_if link ();
   ledks_link_if link2 ();
   ledks_host u_ledks_host (.mclk(mclk), .reset_n(reset_n), .link(link),
      .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
      .req_data(req_data), .req_has_data(req_has_data),
      .req_read(req_read), .rsp_valid(rsp_valid), .rsp_keys(rsp_keys));
   ledks_dev #(.SLOT_CYCLES(SLOT)) u_ledks_dev (.mclk(mclk),
      .reset_n(reset_n), .link(link), .digit_src_en(dig_a),
      .seg_sink_en(seg_a), .key_src_en(ksrc_a), .scan_return_1(ret_1),
      .scan_return_2(ret_2), .key_irq_n(irq_n), .display_on(on_a));
   // Second device faces the bench's own rule-breaking driver
   ledks_dev #(.SLOT_CYCLES(SLOT)) u_ledks_dev_2 (.mclk(mclk),
      .reset_n(reset_n), .link(link2), .digit_src_en(dig_b),
      .seg_sink_en(seg_b), .key_src_en(), .scan_return_1(1'b0),
      .scan_return_2(1'b0), .key_irq_n(), .display_on(on_b));
   ledks_link_sva u_ledks_link_sva (.mclk(mclk), .reset_n(reset_n),
      .sclk(link.sclk), .frame_select_n(link.frame_select_n),
      .host_dout(link.host_dout), .host_oe(link.host_oe),
      .dev_dout(link.dev_dout), .dev_oe(link.dev_oe), .dio(link.dio));

   initial begin
      forever #2.5 mclk = ~mclk;
   end

   // Key matrix: return high when a pressed key meets its live source
   always @(posedge mclk) begin
      #1;
      ret_1 = |(ksrc_a & pressed[7:0]);
      ret_2 = |(ksrc_a & pressed[15:8]);
   end

   task automatic print_verdict();
      $display("TB: %0d checks, %0d errors", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict

   // A wait that runs out counts as a mismatch and ends the run
   task automatic timed_out();
      error_cnt++;
      $display("ERROR %0t: wait timed out", $time);
      print_verdict();
   endtask : timed_out

   // Ends one time unit after a rising edge, where inputs change
   task automatic cycles(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cycles

   task automatic xfer(input logic [7:0] c, input logic [7:0] d,
         input logic hd, input logic rd);
      int i;
      for (i = 0; i < 400 && req_ready !== 1'b1; i++) cycles(1);
      if (i == 400) timed_out();
      req_valid = 1'b1;
      req_cmd = c;
      req_data = d;
      req_has_data = hd;
      req_read = rd;
      cycles(1);
      req_valid = 1'b0;
      for (i = 0; rd && i < 400 && rsp_valid !== 1'b1; i++) cycles(1);
      if (i == 400) timed_out();
      // Frame must close so its command has landed before checks start
      for (i = 0; i < 400 && req_ready !== 1'b1; i++) cycles(1);
      if (i == 400) timed_out();
      cycles(10);
   endtask : xfer

   // Two scan periods; lit segments must match memory of the live digit
   task automatic scan_chk(input logic en);
      logic [DIG_N-1:0] seen;
      seen = '0;
      repeat (30 * SLOT) begin
         cycles(1);
         seen = seen | dig_a;
         `CHK($onehot0(dig_a), 1'b1)
         `CHK(dig_a != 7'h00 && ksrc_a != 8'h00, 1'b0)
         for (int k = 0; k < DIG_N; k++) begin
            if (dig_a[k]) `CHK(seg_a, mem[k])
         end
         if (!en) `CHK({dig_a, seg_a, ksrc_a}, 23'h000000)
      end
      `CHK(seen, en ? 7'h7F : 7'h00)
   endtask : scan_chk

   // Bench-made link frame on the second device, 15 ns link clock
   task automatic bang(input logic [15:0] v, input int n, input logic hi);
      link2.frame_select_n = hi;
      #7.5;
      for (int b = 0; b < n; b++) begin
         link2.sclk = 1'b0;
         link2.host_oe = 1'b1;
         link2.host_dout = v[b];
         #7.5 link2.sclk = 1'b1;
         #7.5;
      end
      link2.frame_select_n = 1'b1;
      link2.host_oe = 1'b0;
      #100;
   endtask : bang

   task automatic dig0_b(input logic [7:0] exp);
      int i;
      for (i = 0; i < 400 && dig_b[0] !== 1'b1; i++) cycles(1);
      if (i == 400) timed_out();
      `CHK(seg_b, exp)
   endtask : dig0_b

   initial begin
      link2.sclk = 1'b1;
      link2.frame_select_n = 1'b1;
      link2.host_oe = 1'b0;
      link2.host_dout = 1'b0;
      repeat (20) @(posedge mclk);
      #1;
      for (int p = 0; p < 2; p++) begin
         `CHK({on_a, dig_a, seg_a, ksrc_a, irq_n, link.dev_oe, link.dio},
            {1'b0, 23'h000000, 3'b101})
         reset_n = 1'b1;
         cycles(2);
      end
      $display("TB: test reset done");
      for (int k = 0; k < DIG_N; k++) begin
         mem[k] = 8'(8'hA5 ^ (k * 8'h13));
         xfer({OP_WRITE_DIGIT, 2'b00, 3'(k)}, mem[k], 1'b1, 1'b0);
      end
      scan_chk(1'b0);
      xfer(ON, 8'h00, 1'b0, 1'b0);
      scan_chk(1'b1);
      xfer(OFF, 8'h00, 1'b0, 1'b0);
      scan_chk(1'b0);
      xfer(ON, 8'h00, 1'b0, 1'b0);
      scan_chk(1'b1);
      $display("TB: test display done");
      foreach (pats[j]) begin
         pressed = pats[j];
         cycles(40 * SLOT);
         `CHK(irq_n, pats[j] == 16'h0000)
         xfer({OP_READ_KEYS, 5'h00}, 8'h00, 1'b0, 1'b1);
         `CHK(rsp_keys, pats[j])
      end
      $display("TB: test keys done");
      bang({8'hFF, OP_WRITE_DIGIT, 5'h00}, 16, 1'b0);
      bang({8'h00, ON}, 8, 1'b0);
      dig0_b(8'hFF);
      bang({8'h00, OP_WRITE_DIGIT, 5'h00}, 12, 1'b0);
      dig0_b(8'hFF);
      bang({8'h00, OFF}, 8, 1'b1);
      cycles(20);
      `CHK(on_b, 1'b1)
      bang(16'h0005, 3, 1'b0);
      bang({8'h00, OFF}, 8, 1'b0);
      cycles(20);
      `CHK(on_b, 1'b0)
      $display("TB: test framing done");
      print_verdict();
   end
endmodule : led_keyscan_serial_front_end_tb
